// ==== logic/pbsf_bus_cycle.sv ====
// one asynchronous flash bus cycle, write or read, on the device pins
`default_nettype none
module pbsf_bus_cycle
   import pbsf_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // request
   input wire logic start,
   input wire pbsf_cycle_t cyc,
   output logic done,
   output logic [DATA_W-1:0] rdData,
   // pins
   output pbsf_pins_t pins,
   input wire logic [DATA_W-1:0] dqIn
);
   typedef enum logic [2:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_WAIT, PH_RECOVER} pbsf_phase_t;
   localparam pbsf_pins_t PINS_IDLE = '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: '0, dqOut: '0, dqOe: 1'b0};

   pbsf_phase_t ph_r, ph_nxt;
   pbsf_pins_t pins_r, pins_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [DATA_W-1:0] rd_r, rd_nxt;
   logic [DATA_W-1:0] dqS1_r, dqS2_r, dqS3_r;
   logic isRead_r, isRead_nxt;
   logic done_r, done_nxt;

   always_comb begin
      ph_nxt = ph_r;
      pins_nxt = pins_r;
      cnt_nxt = cnt_r;
      rd_nxt = rd_r;
      isRead_nxt = isRead_r;
      done_nxt = 1'b0;
      case (ph_r)
         PH_IDLE: begin
            if (start) begin
               pins_nxt.ceN = 1'b0;
               pins_nxt.addr = cyc.addr;
               pins_nxt.dqOut = cyc.data;
               pins_nxt.dqOe = ~cyc.isRead;
               isRead_nxt = cyc.isRead;
               ph_nxt = PH_SETUP;
            end
         end
         PH_SETUP: begin
            pins_nxt.weN = isRead_r;
            pins_nxt.oeN = ~isRead_r;
            cnt_nxt = isRead_r ? RD_WAIT_CYC : WE_PULSE_CYC;
            ph_nxt = isRead_r ? PH_WAIT : PH_STROBE;
         end
         PH_STROBE: begin
            if (cnt_r == 3'h1) begin
               pins_nxt.weN = 1'b1;
               ph_nxt = PH_RECOVER;
            end
            cnt_nxt = cnt_r - 3'h1;
         end
         PH_WAIT: begin
            // a pin word counts only once two synchroniser stages agree
            if (cnt_r != 3'h0) begin
               cnt_nxt = cnt_r - 3'h1;
            end else if (dqS2_r == dqS3_r) begin
               rd_nxt = dqS3_r;
               pins_nxt.oeN = 1'b1;
               ph_nxt = PH_RECOVER;
            end
         end
         PH_RECOVER: begin
            pins_nxt = PINS_IDLE;
            done_nxt = 1'b1;
            ph_nxt = PH_IDLE;
         end
         default: begin
            pins_nxt = PINS_IDLE;
            ph_nxt = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ph_r <= PH_IDLE;
         pins_r <= PINS_IDLE;
         cnt_r <= 3'h0;
         rd_r <= '0;
         isRead_r <= 1'b0;
         done_r <= 1'b0;
         dqS1_r <= '0;
         dqS2_r <= '0;
         dqS3_r <= '0;
      end else begin
         ph_r <= ph_nxt;
         pins_r <= pins_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         isRead_r <= isRead_nxt;
         done_r <= done_nxt;
         dqS1_r <= dqIn;
         dqS2_r <= dqS1_r;
         dqS3_r <= dqS2_r;
      end
   end

   assign pins = pins_r;
   assign done = done_r;
   assign rdData = rd_r;
endmodule
`default_nettype wire

// ==== logic/pbsf_host_ctrl.sv ====
// host controller that drives flash word and buffer programming with suspend and resume
// What this block does
// - Confirm 29h at buffer sector at -1
// - Timeout hangs with status bit7 set; F0h recovers
// - Suspended: reads, status stay; 50h resumes
// - Use enhanced suspend/resume codes, not legacy
// - Abort recovery is AAh, 55h, F0h at 555h
//
// The register offsets and the strobed register port are this design's own decisions.
`default_nettype none
module pbsf_host_ctrl
   import pbsf_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [REG_AW-1:0] regAddr,
   input wire logic [REG_DW-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [REG_DW-1:0] regRdata,
   // interrupt
   output logic irq,
   // flash pins
   output pbsf_pins_t flashPins,
   input wire logic [DATA_W-1:0] flashDqIn
);
   pbsf_dev_t dev_r, dev_nxt;
   pbsf_op_t op_r, op_nxt;
   logic busy_r, busy_nxt;
   logic pend_r, pend_nxt;
   logic [1:0] step_r, step_nxt;
   logic [CNT_W-1:0] left_r, left_nxt;
   logic [SECT_W-1:0] sect_r, sect_nxt;
   logic [LAT_W-1:0] lat_r, lat_nxt;
   logic [ADDR_W-1:0] addrReg_r, addrReg_nxt;
   logic [DATA_W-1:0] dataReg_r, dataReg_nxt;
   logic [CNT_W-1:0] countReg_r, countReg_nxt;
   logic ersMode_r, ersMode_nxt;
   logic [DATA_W-1:0] stat_r, stat_nxt;
   logic [EV_W-1:0] ev_r, ev_nxt, evEn_r, evEn_nxt, evSet;
   logic [REG_DW-1:0] rdata_r, rdata_nxt;

   pbsf_cycle_t cyc;
   logic lastStep, cycStart, cycDone, legal;
   logic [DATA_W-1:0] cycRd;
   pbsf_op_t reqOp;
   logic [ADDR_W-1:0] sectBase;

   assign sectBase = {sect_r, {SECTOR_LSB{1'b0}}};
   assign reqOp = pbsf_op_t'(regWdata[3:0]);
   assign cycStart = busy_r & ~pend_r & (dev_r != DS_SUSP_REQ);

   pbsf_bus_cycle u_cycle (
      .core_clk(core_clk),
      .rst(rst),
      .start(cycStart),
      .cyc(cyc),
      .done(cycDone),
      .rdData(cycRd),
      .pins(flashPins),
      .dqIn(flashDqIn)
   );

   // bus cycles of each operation, step by step
   always_comb begin
      cyc = '{isRead: 1'b0, addr: UNLOCK1_ADDR, data: CMD_UNLOCK1};
      lastStep = 1'b0;
      case (op_r)
         OP_WORD_PROG, OP_BUF_ENTER, OP_RESET: begin
            case (step_r)
               2'h0: cyc.data = CMD_UNLOCK1;
               2'h1: begin
                  cyc.addr = UNLOCK2_ADDR;
                  cyc.data = CMD_UNLOCK2;
               end
               2'h2: begin
                  if (op_r == OP_WORD_PROG) begin
                     cyc.data = CMD_WORD_PROG;
                  end else if (op_r == OP_BUF_ENTER) begin
                     cyc.addr = sectBase;
                     cyc.data = CMD_BUF_ENTER;
                  end else begin
                     cyc.data = CMD_SW_RESET;
                     lastStep = 1'b1;
                  end
               end
               default: begin
                  lastStep = 1'b1;
                  if (op_r == OP_WORD_PROG) begin
                     cyc.addr = addrReg_r;
                     cyc.data = dataReg_r;
                  end else begin
                     cyc.addr = sectBase;
                     cyc.data = {{(DATA_W-CNT_W){1'b0}}, countReg_r - CNT_ONE};
                  end
               end
            endcase
         end
         OP_BUF_DATA: begin
            cyc.addr = addrReg_r;
            cyc.data = dataReg_r;
            lastStep = 1'b1;
         end
         OP_CONFIRM: begin
            cyc.addr = sectBase;
            cyc.data = CMD_CONFIRM;
            lastStep = 1'b1;
         end
         OP_SUSPEND: begin
            cyc.data = CMD_PROG_SUSPEND;
            lastStep = 1'b1;
         end
         OP_RESUME: begin
            cyc.data = CMD_PROG_RESUME;
            lastStep = 1'b1;
         end
         OP_STATUS: begin
            if (step_r == 2'h0) begin
               cyc.data = CMD_STAT_READ;
            end else begin
               cyc.isRead = 1'b1;
               cyc.addr = sectBase;
               lastStep = 1'b1;
            end
         end
         default: lastStep = 1'b1;
      endcase
   end

   // which orders the device accepts in its present state; the rest are refused
   always_comb begin
      legal = 1'b0;
      case (reqOp)
         OP_WORD_PROG, OP_BUF_ENTER: legal = (dev_r == DS_IDLE) && (countReg_r != '0)
            && (countReg_r <= BUF_MAX_CNT + CNT_ONE);
         OP_BUF_DATA: legal = (dev_r == DS_LOADING) && !left_r[CNT_W-1]
            && (addrReg_r[ADDR_W-1:SECTOR_LSB] == sect_r);
         OP_CONFIRM: legal = (dev_r == DS_LOADING) && (left_r == CNT_DONE);
         OP_SUSPEND: legal = (dev_r == DS_PROGRAMMING);
         OP_RESUME: legal = (dev_r == DS_SUSPENDED);
         OP_RESET: legal = (dev_r == DS_HANG) || (dev_r == DS_ABORT);
         OP_STATUS: legal = (dev_r != DS_LOADING);
         default: legal = 1'b0;
      endcase
   end

   // operation sequencing and the device state as the host tracks it
   always_comb begin
      dev_nxt = dev_r;
      op_nxt = op_r;
      busy_nxt = busy_r;
      pend_nxt = pend_r;
      step_nxt = step_r;
      left_nxt = left_r;
      sect_nxt = sect_r;
      lat_nxt = lat_r;
      stat_nxt = stat_r;
      evSet = '0;
      if (cycStart) begin
         pend_nxt = 1'b1;
      end
      if (dev_r == DS_SUSP_REQ) begin
         // suspend needs no poll, the device settles within the latency
         if (lat_r == '0) begin
            dev_nxt = DS_SUSPENDED;
            evSet[EV_SUSPENDED] = 1'b1;
            busy_nxt = 1'b0;
         end else begin
            lat_nxt = lat_r - {{(LAT_W-1){1'b0}}, 1'b1};
         end
      end
      if (cycDone) begin
         pend_nxt = 1'b0;
         if (!lastStep) begin
            step_nxt = step_r + 2'h1;
         end else begin
            busy_nxt = 1'b0;
            case (op_r)
               OP_WORD_PROG, OP_CONFIRM, OP_RESUME: dev_nxt = DS_PROGRAMMING;
               OP_BUF_ENTER: begin
                  dev_nxt = DS_LOADING;
                  left_nxt = countReg_r - CNT_ONE;
               end
               OP_BUF_DATA: left_nxt = left_r - CNT_ONE;
               OP_SUSPEND: begin
                  dev_nxt = DS_SUSP_REQ;
                  busy_nxt = 1'b1;
                  lat_nxt = LAT_W'(SUSP_LAT_CYC);
               end
               OP_RESET: dev_nxt = DS_IDLE;
               OP_STATUS: begin
                  stat_nxt = cycRd;
                  lat_nxt = POLL_GAP_CYC;
                  if (dev_r == DS_PROGRAMMING && cycRd[STAT_READY_BIT]) begin
                     if (cycRd[STAT_ERR_BIT]) begin
                        dev_nxt = DS_HANG;
                        evSet[EV_HANG] = 1'b1;
                     end else begin
                        // idle means read mode or erase suspend, per ersMode
                        dev_nxt = DS_IDLE;
                        evSet[EV_DONE] = 1'b1;
                     end
                  end
               end
               default: dev_nxt = dev_r;
            endcase
         end
      end
      if (regWr && regAddr == REG_CMD) begin
         if (!busy_r && legal) begin
            op_nxt = reqOp;
            busy_nxt = 1'b1;
            step_nxt = 2'h0;
            if (reqOp == OP_WORD_PROG || reqOp == OP_BUF_ENTER) begin
               sect_nxt = addrReg_r[ADDR_W-1:SECTOR_LSB];
            end
         end else begin
            evSet[EV_REFUSED] = 1'b1;
         end
      end else if (!busy_r && dev_r == DS_PROGRAMMING) begin
         // poll while programming; the gap between polls leaves room for a suspend order
         if (lat_r == '0) begin
            op_nxt = OP_STATUS;
            busy_nxt = 1'b1;
            step_nxt = 2'h0;
         end else begin
            lat_nxt = lat_r - {{(LAT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // software registers
   always_comb begin
      addrReg_nxt = addrReg_r;
      dataReg_nxt = dataReg_r;
      countReg_nxt = countReg_r;
      ersMode_nxt = ersMode_r;
      evEn_nxt = evEn_r;
      ev_nxt = ev_r;
      rdata_nxt = '0;
      if (regWr) begin
         case (regAddr)
            REG_ADDR: addrReg_nxt = regWdata[ADDR_W-1:0];
            REG_DATA: dataReg_nxt = regWdata[DATA_W-1:0];
            REG_COUNT: countReg_nxt = regWdata[CNT_W-1:0];
            // mode may change only while no program is open
            REG_CTRL: ersMode_nxt = (dev_r == DS_IDLE) ? regWdata[0] : ersMode_r;
            REG_IRQ_CLR: ev_nxt = ev_r & ~regWdata[EV_W-1:0];
            REG_IRQ_EN: evEn_nxt = regWdata[EV_W-1:0];
            default: ev_nxt = ev_r;
         endcase
      end
      // a new event wins over a clear in the same cycle
      ev_nxt = ev_nxt | evSet;
      if (regRd) begin
         case (regAddr)
            REG_ADDR: rdata_nxt = {{(REG_DW-ADDR_W){1'b0}}, addrReg_r};
            REG_DATA: rdata_nxt = {{(REG_DW-DATA_W){1'b0}}, dataReg_r};
            REG_COUNT: rdata_nxt = {{(REG_DW-CNT_W){1'b0}}, countReg_r};
            REG_CTRL: rdata_nxt = {{(REG_DW-1){1'b0}}, ersMode_r};
            REG_STATE: rdata_nxt = {{(REG_DW-CNT_W-9){1'b0}}, left_r, op_r, busy_r, dev_r, ersMode_r};
            REG_POLL: rdata_nxt = {{(REG_DW-DATA_W){1'b0}}, stat_r};
            REG_IRQ_STAT: rdata_nxt = {{(REG_DW-EV_W){1'b0}}, ev_r};
            REG_IRQ_EN: rdata_nxt = {{(REG_DW-EV_W){1'b0}}, evEn_r};
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dev_r <= DS_IDLE;
         op_r <= OP_NONE;
         busy_r <= 1'b0;
         pend_r <= 1'b0;
         step_r <= 2'h0;
         left_r <= CNT_DONE;
         sect_r <= '0;
         lat_r <= '0;
         stat_r <= '0;
         addrReg_r <= '0;
         dataReg_r <= '0;
         countReg_r <= '0;
         ersMode_r <= 1'b0;
         ev_r <= '0;
         evEn_r <= '0;
         rdata_r <= '0;
      end else begin
         dev_r <= dev_nxt;
         op_r <= op_nxt;
         busy_r <= busy_nxt;
         pend_r <= pend_nxt;
         step_r <= step_nxt;
         left_r <= left_nxt;
         sect_r <= sect_nxt;
         lat_r <= lat_nxt;
         stat_r <= stat_nxt;
         addrReg_r <= addrReg_nxt;
         dataReg_r <= dataReg_nxt;
         countReg_r <= countReg_nxt;
         ersMode_r <= ersMode_nxt;
         ev_r <= ev_nxt;
         evEn_r <= evEn_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign irq = |(ev_r & evEn_r);
endmodule
`default_nettype wire

// ==== logic/pbsf_pkg.sv ====
// shared constants, types and register map of the flash program host controller
`default_nettype none
package pbsf_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int REG_AW = 8;
   localparam int REG_DW = 32;
   localparam int SECTOR_LSB = 15;
   localparam int SECT_W = ADDR_W - SECTOR_LSB;
   localparam int CNT_W = 9;
   // device command addresses and codes
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002aa;
   localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00aa;
   localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_WORD_PROG = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_BUF_ENTER = 16'h0025;
   localparam logic [DATA_W-1:0] CMD_CONFIRM = 16'h0029;
   localparam logic [DATA_W-1:0] CMD_PROG_SUSPEND = 16'h0051;
   localparam logic [DATA_W-1:0] CMD_PROG_RESUME = 16'h0050;
   localparam logic [DATA_W-1:0] CMD_SW_RESET = 16'h00f0;
   localparam logic [DATA_W-1:0] CMD_STAT_READ = 16'h0070;
   // buffer limits
   localparam logic [CNT_W-1:0] BUF_MAX_CNT = 9'h07f;
   localparam logic [CNT_W-1:0] CNT_DONE = 9'h1ff;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   // device status bits
   localparam int STAT_READY_BIT = 7;
   localparam int STAT_ERR_BIT = 4;
   // timing
   localparam int CLK_MHZ = 10;
   localparam int SUSP_LAT_US = 40;
   localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;
   localparam int LAT_W = 12;
   localparam logic [LAT_W-1:0] POLL_GAP_CYC = 12'h008;
   localparam logic [2:0] WE_PULSE_CYC = 3'h1;
   localparam logic [2:0] RD_WAIT_CYC = 3'h3;
   // register offsets
   localparam logic [REG_AW-1:0] REG_CMD = 8'h00;
   localparam logic [REG_AW-1:0] REG_ADDR = 8'h04;
   localparam logic [REG_AW-1:0] REG_DATA = 8'h08;
   localparam logic [REG_AW-1:0] REG_COUNT = 8'h0c;
   localparam logic [REG_AW-1:0] REG_CTRL = 8'h10;
   localparam logic [REG_AW-1:0] REG_STATE = 8'h14;
   localparam logic [REG_AW-1:0] REG_POLL = 8'h18;
   localparam logic [REG_AW-1:0] REG_IRQ_STAT = 8'h1c;
   localparam logic [REG_AW-1:0] REG_IRQ_CLR = 8'h20;
   localparam logic [REG_AW-1:0] REG_IRQ_EN = 8'h24;
   // event bits
   localparam int EV_W = 4;
   localparam int EV_DONE = 0;
   localparam int EV_HANG = 1;
   localparam int EV_REFUSED = 2;
   localparam int EV_SUSPENDED = 3;

   typedef enum logic [3:0] {
      OP_NONE, OP_WORD_PROG, OP_BUF_ENTER, OP_BUF_DATA, OP_CONFIRM,
      OP_SUSPEND, OP_RESUME, OP_RESET, OP_STATUS
   } pbsf_op_t;

   typedef enum logic [2:0] {
      DS_IDLE, DS_LOADING, DS_PROGRAMMING, DS_SUSP_REQ, DS_SUSPENDED, DS_HANG, DS_ABORT
   } pbsf_dev_t;

   typedef struct packed {
      logic isRead;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pbsf_cycle_t;

   typedef struct packed {
      logic ceN;
      logic weN;
      logic oeN;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dqOut;
      logic dqOe;
   } pbsf_pins_t;
endpackage
`default_nettype wire

// ==== verif/pbsf_flash_model.sv ====
// behavioural flash device: decoder, buffer load, program timer, suspend
`default_nettype none
module pbsf_flash_model
   import pbsf_pkg::*;
#(
   parameter int PROG_CYC = 600,
   parameter int LAT_CYC = 100
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // scenario control
   input wire logic hangMode,
   output logic aborted,
   // pins
   input wire pbsf_pins_t pins,
   output logic [DATA_W-1:0] dq
);
   timeunit 1ns;
   timeprecision 1ns;
   // st: 0 read or erase-suspended, 1 load, 2 prog, 3 susp req, 4 suspended, 5 hang, 6 abort, 7 setup
   logic [2:0] st;
   logic [1:0] ul;
   logic weQ;
   logic statMode;
   logic cntNext;
   logic [SECT_W-1:0] sa;
   logic [DATA_W-1:0] spin;
   int left;
   int tmr;
   int lat;
   wire logic [DATA_W-1:0] d = pins.dqOut;
   wire logic same = pins.addr[ADDR_W-1:SECTOR_LSB] == sa;
   wire logic [DATA_W-1:0] stw = {8'h00, st != 3'h2 && st != 3'h3, 2'h0, st == 3'h5, 4'h0};
   // released bus shows a moving pattern, never a stale word
   assign dq = (!pins.ceN && !pins.oeN) ? (statMode ? stw : 16'h0000) : spin;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= 3'h0;
         ul <= 2'h0;
         weQ <= 1'b1;
         statMode <= 1'b0;
         cntNext <= 1'b0;
         spin <= 16'h5a5a;
         aborted <= 1'b0;
      end else begin
         weQ <= pins.weN;
         spin <= ~spin + 16'h0001;
         if (st == 3'h6) aborted <= 1'b1;
         if (st == 3'h2) begin
            tmr <= tmr + 1;
            if (tmr >= PROG_CYC) st <= hangMode ? 3'h5 : 3'h0;
         end
         if (st == 3'h3) begin
            lat <= lat + 1;
            if (lat >= LAT_CYC) st <= 3'h4;
         end
         if (pins.weN && !weQ && !pins.ceN) begin
            statMode <= d == CMD_STAT_READ && pins.addr == UNLOCK1_ADDR;
            ul <= (d == CMD_UNLOCK1) ? 2'h1 : (ul == 2'h1 && d == CMD_UNLOCK2) ? 2'h2 : 2'h0;
            case (st)
               3'h0: if (ul == 2'h2 && d == CMD_WORD_PROG) st <= 3'h7;
                  else if (ul == 2'h2 && d == CMD_BUF_ENTER) begin
                     st <= 3'h1;
                     sa <= pins.addr[ADDR_W-1:SECTOR_LSB];
                     cntNext <= 1'b1;
                  end
               3'h1: if (cntNext) begin
                     left <= int'(d);
                     cntNext <= 1'b0;
                  end else if (left < 0) begin
                     st <= (d == CMD_CONFIRM && same) ? 3'h2 : 3'h6;
                     tmr <= 0;
                  end else if (left > 127 || !same) st <= 3'h6;
                  else left <= left - 1;
               3'h7: begin
                  st <= 3'h2;
                  tmr <= 0;
               end
               3'h2: if (d == CMD_PROG_SUSPEND || d == 16'h00b0) begin
                     st <= 3'h3;
                     lat <= 0;
                  end
               3'h4: if (d == CMD_PROG_RESUME || d == 16'h0030) st <= 3'h2;
               3'h5: if (d == CMD_SW_RESET) st <= 3'h0;
               3'h6: if (ul == 2'h2 && d == CMD_SW_RESET) st <= 3'h0;
               default: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/pbsf_host_ctrl_properties.sv ====
// pin and register port checker of the flash program host controller
`default_nettype none
module pbsf_host_ctrl_props
   import pbsf_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [REG_AW-1:0] regAddr,
   input wire logic [REG_DW-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [REG_DW-1:0] regRdata,
   // interrupt and pins
   input wire logic irq,
   input wire pbsf_pins_t flashPins,
   input wire logic [DATA_W-1:0] flashDqIn
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // previous written word; a0 before means user data, so command checks skip it
   logic weQ_r;
   logic [DATA_W-1:0] prevData_r;
   wire logic weRise = flashPins.weN && !weQ_r;
   wire logic notData = prevData_r != CMD_WORD_PROG;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         weQ_r <= 1'b1;
         prevData_r <= 16'h0000;
      end else begin
         weQ_r <= flashPins.weN;
         if (weRise) begin
            prevData_r <= flashPins.dqOut;
         end
      end
   end
   a_we_inside_ce: assert property ($fell(flashPins.weN) |-> !flashPins.ceN && !$past(flashPins.ceN))
      else $error("write strobe outside chip select");
   a_we_one_cycle: assert property ($fell(flashPins.weN) |=> flashPins.weN)
      else $error("write strobe not one cycle long");
   a_ce_idle_gap: assert property ($rose(flashPins.ceN) |=> flashPins.ceN)
      else $error("no idle cycle between bus cycles");
   a_pins_held: assert property (!flashPins.ceN && !$past(flashPins.ceN)
      |-> $stable(flashPins.addr) && $stable(flashPins.dqOut))
      else $error("address or data moved inside a bus cycle");
   a_oe_excl: assert property (!flashPins.oeN |-> !flashPins.dqOe && flashPins.weN)
      else $error("read overlaps a drive or write");
   a_no_legacy: assert property (weRise && flashPins.addr == UNLOCK1_ADDR && notData
      |-> flashPins.dqOut != 16'h00b0 && flashPins.dqOut != 16'h0030)
      else $error("legacy suspend or resume code written");
   a_unlock_pair: assert property (weRise && flashPins.addr == UNLOCK2_ADDR && notData
      && flashPins.dqOut == CMD_UNLOCK2 |-> prevData_r == CMD_UNLOCK1)
      else $error("second unlock without first");
   a_reset_unlocked: assert property (weRise && flashPins.addr == UNLOCK1_ADDR && notData
      && flashPins.dqOut == CMD_SW_RESET |-> prevData_r == CMD_UNLOCK2)
      else $error("reset code without unlock");
   a_rd_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ==== verif/test_pbsf_host_ctrl.sv ====
// self-checking bench of the flash program host controller
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_pbsf_host_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   import pbsf_pkg::*;
   logic core_clk = 1'b0;
   logic rst;
   logic [REG_AW-1:0] regAddr;
   logic [REG_DW-1:0] regWdata;
   logic regWr;
   logic regRd;
   logic [REG_DW-1:0] regRdata;
   logic irq;
   pbsf_pins_t flashPins;
   logic [DATA_W-1:0] flashDqIn;
   logic hangMode;
   logic aborted;
   int failures;
   int checks;
   always #50 core_clk = ~core_clk;
   pbsf_host_ctrl dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .irq(irq), .flashPins(flashPins), .flashDqIn(flashDqIn));
   pbsf_flash_model flash (.core_clk(core_clk), .rst(rst), .hangMode(hangMode), .aborted(aborted),
      .pins(flashPins), .dq(flashDqIn));
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic chk(input string n, input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] m,
      input logic [REG_DW-1:0] e);
      logic [REG_DW-1:0] v;
      rd(a, v);
      `CHK(n, e, v & m)
   endtask
   task automatic waitReg(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] m, input logic [REG_DW-1:0] e,
      input int n);
      logic [REG_DW-1:0] v;
      checks++;
      for (int i = 0; i < n; i++) begin
         rd(a, v);
         if ((v & m) === e) return;
      end
      failures++;
      $display("[FAIL] wait on reg %h exp %h got %h", a, e, v & m);
      report_and_stop();
   endtask
   task automatic refuse(input logic [3:0] op);
      wr(REG_CMD, {28'h0, op});
      chk("refused event", REG_IRQ_STAT, 32'h4, 32'h4);
      wr(REG_IRQ_CLR, 32'h4);
   endtask
   // word program, with suspend and resume or with a hang and reset
   task automatic progRun(input logic ers, input logic hang);
      wr(REG_CTRL, {31'h0, ers});
      hangMode <= hang;
      wr(REG_ADDR, 32'h20010);
      wr(REG_DATA, 32'h1234);
      wr(REG_CMD, 32'h1);
      if (!hang) begin
         waitReg(REG_STATE, 32'h1e, 32'h4, 50);
         wr(REG_CMD, 32'h5);
         waitReg(REG_STATE, 32'h0e, 32'h6, 20);
         waitReg(REG_STATE, 32'h1e, 32'h8, 400);
         chk("suspend event", REG_IRQ_STAT, 32'h8, 32'h8);
         wr(REG_CMD, 32'h8);
         waitReg(REG_STATE, 32'h1e, 32'h8, 50);
         wr(REG_CMD, 32'h6);
         waitReg(REG_IRQ_STAT, 32'h1, 32'h1, 1000);
      end else begin
         waitReg(REG_IRQ_STAT, 32'h2, 32'h2, 1000);
         chk("hang state", REG_STATE, 32'h1e, 32'ha);
         chk("status bit7", REG_POLL, 32'h80, 32'h80);
         hangMode <= 1'b0;
         wr(REG_CMD, 32'h7);
         waitReg(REG_STATE, 32'h1e, 32'h0, 50);
      end
      chk("home state", REG_STATE, 32'h1f, {31'h0, ers});
      wr(REG_IRQ_CLR, 32'hf);
      $display("test program ers=%0d hang=%0d done", ers, hang);
   endtask
   initial begin
      rst = 1'b1;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      hangMode = 1'b0;
      failures = 0;
      checks = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      chk("state at reset", REG_STATE, 32'h3ffff, 32'h3fe00);
      chk("unmapped read", 8'hfc, 32'hffffffff, 32'h0);
      // masked event keeps the line low
      wr(REG_CMD, 32'h6);
      chk("refused only", REG_IRQ_STAT, 32'hf, 32'h4);
      chk("state kept", REG_STATE, 32'h1f, 32'h0);
      `CHK("masked irq", 1'b0, irq)
      wr(REG_IRQ_EN, 32'hf);
      chk("irq enable", REG_IRQ_EN, 32'hf, 32'hf);
      `CHK("irq raised", 1'b1, irq)
      wr(REG_IRQ_CLR, 32'hf);
      chk("irq cleared", REG_IRQ_STAT, 32'hf, 32'h0);
      `CHK("irq low", 1'b0, irq)
      $display("test registers done");
      wr(REG_ADDR, 32'h18000);
      wr(REG_COUNT, 32'h81);
      refuse(4'h2);
      wr(REG_COUNT, 32'h80);
      wr(REG_CMD, 32'h2);
      waitReg(REG_STATE, 32'h3fe1e, 32'hfe02, 100);
      refuse(4'h4);
      wr(REG_ADDR, 32'h28000);
      refuse(4'h3);
      for (int i = 0; i < 128; i++) begin
         wr(REG_ADDR, 32'h18000 + i);
         wr(REG_DATA, 32'h1000 + i);
         wr(REG_CMD, 32'h3);
         waitReg(REG_STATE, 32'h1e, 32'h2, 50);
      end
      chk("count spent", REG_STATE, 32'h3fe1e, 32'h3fe02);
      refuse(4'h3);
      wr(REG_CMD, 32'h4);
      waitReg(REG_IRQ_STAT, 32'h1, 32'h1, 1000);
      chk("buffer done", REG_STATE, 32'h1e, 32'h0);
      `CHK("no abort", 1'b0, aborted)
      wr(REG_IRQ_CLR, 32'hf);
      $display("test buffer done");
      for (int k = 0; k < 4; k++) begin
         progRun(k[1], k[0]);
      end
      report_and_stop();
   end
endmodule
bind pbsf_host_ctrl pbsf_host_ctrl_props u_props (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .flashPins(flashPins),
   .flashDqIn(flashDqIn));
`undef CHK
`default_nettype wire
